// ===== src/ahk_half_key_builder.sv
`timescale 1ns/1ns
module ahk_half_key_builder #(
    parameter int CNT_W = 32
) (
    input  wire logic                          pclk,          // core clock
    input  wire logic                          presetn,       // async reset
    input  wire logic                          psel,          // apb select
    input  wire logic                          penable,       // apb enable
    input  wire logic                          pwrite,        // apb write
    input  wire logic [11:0]                   paddr,         // apb address
    input  wire logic [31:0]                   pwdata,        // apb wdata
    output logic [31:0]                        prdata,        // apb rdata
    output logic                               pready,        // apb ready
    output logic                               pslverr,       // apb error
    input  wire logic                          fr_valid,      // frame valid
    output logic                               fr_ready,      // frame taken
    input  wire logic [3:0]                    fr_class,      // frame class
    input  wire logic [ahk_pkg::PG_W-1:0]      policy_group,  // first stage
    input  wire logic [ahk_pkg::PORT_IDX_W-1:0] fr_port,      // rx port
    input  wire logic                          host_match,    // host result
    input  wire logic                          host_used,     // host valid
    input  wire logic [ahk_pkg::MAC_W-1:0]     fr_dmac,       // dest mac
    input  wire logic [ahk_pkg::MAC_W-1:0]     fr_smac,       // source mac
    input  wire logic [1:0]                    fr_qtag_cnt,   // q-tags seen
    input  wire logic [ahk_pkg::VID_W-1:0]     fr_vid,        // class vid
    input  wire logic                          fr_dei,        // class dei
    input  wire logic [ahk_pkg::PCP_W-1:0]     fr_pcp,        // class pcp
    input  wire logic [ahk_pkg::ET_W-1:0]      fr_ethertype,  // after tags
    input  wire logic [ahk_pkg::PAYLOAD_W-1:0] fr_payload,    // bytes 0..6
    output logic                               key_valid,     // key offered
    input  wire logic                          key_ready,     // key taken
    output logic [ahk_pkg::KEY_W-1:0]          key_data,      // key bits
    output logic [ahk_pkg::KEY_W-1:0]          key_care,      // 1 = compare
    output logic                               key_first,     // lookup 1
    output logic [7:0]                         key_depth      // table depth
);
    import ahk_pkg::*;

    typedef enum logic [1:0] {
        S_IDLE,
        S_FIRST,
        S_SECOND
    } ahk_state_t;

    ahk_state_t           state_r;
    logic [KEY_W-1:0]     key_r;
    logic [KEY_W-1:0]     care_r;
    logic [7:0]           depth_r;
    logic                 en_r;
    logic [CNT_W-1:0]     frames_r;
    logic [CNT_W-1:0]     keys_r;
    logic [TYPE_W-1:0]    last_type_r;
    logic [KEY_W-1:0]     key_nxt;
    logic [KEY_W-1:0]     care_nxt;
    logic [7:0]           depth_nxt;
    logic [TYPE_W-1:0]    type_nxt;
    logic [PORT_W-1:0]    port_onehot;
    logic                 dmac_mc;
    logic                 dmac_bc;
    logic                 take;
    logic                 key_done;
    logic                 apb_wr;
    logic                 apb_rd;
    logic                 addr_ok;
    logic                 clr_pulse;
    logic [7:0]           pl_byte4;
    logic [7:0]           pl_byte6;

    ahk_mac_class u_mac_class (
        .mac       (fr_dmac),
        .multicast (dmac_mc),
        .broadcast (dmac_bc)
    );

    // only the idle state accepts; keys of one frame are never interleaved
    assign fr_ready  = (state_r == S_IDLE) && en_r;
    assign take      = fr_valid && fr_ready;
    assign key_valid = (state_r != S_IDLE);
    assign key_done  = key_valid && key_ready;
    assign key_data  = key_r;
    assign key_care  = care_r;
    assign key_depth = depth_r;
    assign key_first = key_r[FIRST_BIT];

    assign pl_byte4 = fr_payload[PAYLOAD_W-1-8*4 -: 8];
    assign pl_byte6 = fr_payload[PAYLOAD_W-1-8*6 -: 8];

    // out-of-range port index yields an empty mask rather than wrapping
    always_comb begin
        port_onehot = '0;
        if (fr_port < PORT_IDX_W'(PORT_W)) begin
            port_onehot[fr_port] = 1'b1;
        end
    end

    always_comb begin
        unique case (fr_class)
            AHK_CL_IP6_L4,
            AHK_CL_IP6_OTH: begin
                type_nxt  = HT_IP6;
                depth_nxt = DEPTH_HALF;
            end
            AHK_CL_ETHERTYPE_FIELD,
            AHK_CL_LLC,
            AHK_CL_SNAP,
            AHK_CL_ARP,
            AHK_CL_IP4_L4,
            AHK_CL_IP4_OTH,
            AHK_CL_IP6_STD,
            AHK_CL_OAM,
            AHK_CL_HOST: begin
                type_nxt  = fr_class;
                depth_nxt = DEPTH_FULL;
            end
            default: begin
                // unknown class falls back to the plain ethertype layout
                type_nxt  = HT_ETHERTYPE_FIELD;
                depth_nxt = DEPTH_FULL;
            end
        endcase
    end

    always_comb begin
        key_nxt  = '0;
        care_nxt = '0;
        key_nxt[TYPE_LSB +: TYPE_W] = type_nxt;
        key_nxt[FIRST_BIT]          = 1'b1;
        key_nxt[PG_LSB +: PG_W]     = policy_group;
        key_nxt[PORT_LSB +: PORT_W] = port_onehot;
        key_nxt[HOST_BIT]           = host_used & host_match;
        key_nxt[MC_BIT]             = dmac_mc;
        key_nxt[BC_BIT]             = dmac_bc;
        key_nxt[TAG_BIT]            = |fr_qtag_cnt;
        key_nxt[VID_LSB +: VID_W]   = fr_vid;
        key_nxt[DEI_BIT]            = fr_dei;
        key_nxt[PCP_LSB +: PCP_W]   = fr_pcp;
        care_nxt[COMMON_W-1:0]      = '1;
        care_nxt[HOST_BIT]          = host_used;
        if (type_nxt == HT_ETHERTYPE_FIELD) begin
            key_nxt[DMAC_LSB +: MAC_W] = fr_dmac;
            key_nxt[SMAC_LSB +: MAC_W] = fr_smac;
            key_nxt[ET_LSB +: ET_W]    = fr_ethertype;
            key_nxt[PL0_LSB +: PL0_W]  =
                fr_payload[PAYLOAD_W-1 -: PL0_W];
            key_nxt[PL1_LSB +: PL1_W]  = pl_byte4;
            key_nxt[PL2_LSB +: PL2_W]  =
                {pl_byte6[7], pl_byte6[2], pl_byte6[1]};
            care_nxt[KEY_W-1:COMMON_W] = '1;
        end
    end

    // two keys per frame, no bypass for any class
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (take) begin
                        state_r <= S_FIRST;
                    end
                end
                S_FIRST: begin
                    if (key_ready) begin
                        state_r <= S_SECOND;
                    end
                end
                S_SECOND: begin
                    if (key_ready) begin
                        state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // the second key reuses the held snapshot; only the lookup bit moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_r   <= '0;
            care_r  <= '0;
            depth_r <= '0;
        end else if (take) begin
            key_r   <= key_nxt;
            care_r  <= care_nxt;
            depth_r <= depth_nxt;
        end else if (state_r == S_FIRST && key_ready) begin
            key_r[FIRST_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_type_r <= '0;
        end else if (take) begin
            last_type_r <= type_nxt;
        end
    end

    // apb: zero wait states; unmapped addresses answer with pslverr
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;
    always_comb begin
        unique case (paddr)
            REG_CTRL,
            REG_STATUS,
            REG_FRAMES,
            REG_KEYS: addr_ok = 1'b1;
            default:  addr_ok = 1'b0;
        endcase
    end
    assign pslverr   = psel && penable && !addr_ok;
    assign clr_pulse = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_CLR_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= CTRL_EN_RST;
        end else if (apb_wr && paddr == REG_CTRL) begin
            en_r <= pwdata[CTRL_EN_BIT];
        end
    end

    // a clear in the same cycle as a count still records that event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_r <= '0;
        end else if (clr_pulse) begin
            frames_r <= CNT_W'(take);
        end else if (take) begin
            frames_r <= frames_r + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keys_r <= '0;
        end else if (clr_pulse) begin
            keys_r <= CNT_W'(key_done);
        end else if (key_done) begin
            keys_r <= keys_r + CNT_W'(1);
        end
    end

    // read data is registered in the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_rd && !penable) begin
            prdata <= '0;
            unique case (paddr)
                REG_CTRL: begin
                    prdata[CTRL_EN_BIT] <= en_r;
                end
                REG_STATUS: begin
                    prdata[ST_BUSY_BIT]  <= key_valid;
                    prdata[ST_FIRST_BIT] <= key_valid && key_r[FIRST_BIT];
                    prdata[ST_TYPE_LSB +: TYPE_W] <= last_type_r;
                    prdata[ST_DEPTH_LSB +: 8]     <= depth_r;
                end
                REG_FRAMES: begin
                    prdata <= 32'(frames_r);
                end
                REG_KEYS: begin
                    prdata <= 32'(keys_r);
                end
                default: begin
                    prdata <= '0;
                end
            endcase
        end
    end
endmodule

// ===== src/ahk_mac_class.sv
`timescale 1ns/1ns
module ahk_mac_class
    import ahk_pkg::*;
(
    input  wire logic [MAC_W-1:0] mac,       // destination mac
    output logic                  multicast, // group bit set
    output logic                  broadcast  // all ones
);
    assign multicast = mac[MC_GRP_BIT];
    assign broadcast = &mac;
endmodule

// ===== src/ahk_pkg.sv
package ahk_pkg;
    localparam int KEY_W      = 185;
    localparam int TYPE_LSB   = 0;
    localparam int TYPE_W     = 4;
    localparam int FIRST_BIT  = 4;
    localparam int PG_LSB     = 5;
    localparam int PG_W       = 8;
    localparam int PORT_LSB   = 13;
    localparam int PORT_W     = 12;
    localparam int HOST_BIT   = 26;
    localparam int MC_BIT     = 27;
    localparam int BC_BIT     = 28;
    localparam int TAG_BIT    = 29;
    localparam int VID_LSB    = 30;
    localparam int VID_W      = 12;
    localparam int DEI_BIT    = 42;
    localparam int PCP_LSB    = 43;
    localparam int PCP_W      = 3;
    localparam int COMMON_W   = 46;
    localparam int DMAC_LSB   = 46;
    localparam int SMAC_LSB   = 94;
    localparam int MAC_W      = 48;
    localparam int MC_GRP_BIT = 40;
    localparam int ET_LSB     = 142;
    localparam int ET_W       = 16;
    localparam int PL0_LSB    = 158;
    localparam int PL0_W      = 16;
    localparam int PL1_LSB    = 174;
    localparam int PL1_W      = 8;
    localparam int PL2_LSB    = 182;
    localparam int PL2_W      = 3;
    localparam int PAYLOAD_W  = 56;
    localparam int PORT_IDX_W = 4;
    localparam logic [7:0] DEPTH_FULL = 8'h80;
    localparam logic [7:0] DEPTH_HALF = 8'h40;

    // frame classes from the parser; ipv6 l4/other have own codes but share the std key type
    typedef enum logic [3:0] {
        AHK_CL_ETHERTYPE_FIELD   = 4'h0,
        AHK_CL_LLC     = 4'h1,
        AHK_CL_SNAP    = 4'h2,
        AHK_CL_ARP     = 4'h3,
        AHK_CL_IP4_L4  = 4'h4,
        AHK_CL_IP4_OTH = 4'h5,
        AHK_CL_IP6_STD = 4'h6,
        AHK_CL_OAM     = 4'h7,
        AHK_CL_HOST    = 4'h8,
        AHK_CL_IP6_L4  = 4'h9,
        AHK_CL_IP6_OTH = 4'ha
    } ahk_class_t;

    localparam logic [3:0] HT_ETHERTYPE_FIELD = 4'h0;
    localparam logic [3:0] HT_IP6   = 4'h6;

    // apb map
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_FRAMES  = 12'h008;
    localparam logic [11:0] REG_KEYS    = 12'h00c;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_CLR_BIT   = 1;
    localparam logic CTRL_EN_RST  = 1'b1;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_FIRST_BIT   = 1;
    localparam int ST_TYPE_LSB    = 4;
    localparam int ST_DEPTH_LSB   = 8;
endpackage

// ===== test/ahk_chk.sv
`timescale 1ns/1ns
module ahk_chk
    import ahk_pkg::*;
(
    input wire logic             pclk,      // core clock
    input wire logic             presetn,   // async reset
    input wire logic             fr_valid,  // frame valid
    input wire logic             fr_ready,  // frame taken
    input wire logic             key_valid, // key offered
    input wire logic             key_ready, // key taken
    input wire logic [KEY_W-1:0] key_data,  // key bits
    input wire logic [KEY_W-1:0] key_care,  // compare mask
    input wire logic             key_first, // lookup 1
    input wire logic [7:0]       key_depth  // table depth
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_take_answer: assert property (
        fr_valid && fr_ready |=> key_valid && key_first)
        else $error("no first key after frame taken");
    chk_second_key: assert property (
        key_valid && key_ready && key_first |=> key_valid && !key_first)
        else $error("second key missing");
    chk_pair_same: assert property (
        key_valid && key_ready && key_first |=> $stable(key_care)
        && $stable(key_depth) && $stable(key_data[184:5]))
        else $error("keys of one frame differ");
    chk_key_hold: assert property (
        key_valid && !key_ready |=> key_valid && $stable(key_data))
        else $error("key dropped before accept");
    chk_pair_done: assert property (
        key_valid && key_ready && !key_first |=> !key_valid)
        else $error("extra key after pair");
    chk_busy_refuse: assert property (
        key_valid |-> !fr_ready)
        else $error("frame accepted while keys pending");
    chk_first_bit: assert property (
        key_valid && key_ready && key_first |=> !key_data[4])
        else $error("second key keeps bit 4 set");
    chk_port_onehot: assert property (
        key_valid |-> $onehot0(key_data[24:13]))
        else $error("port mask not one hot");
    chk_host_care: assert property (
        key_valid && !key_care[26] |-> !key_data[26])
        else $error("host bit set while unused");
    chk_mc_bc: assert property (
        key_valid && key_care[46] |-> key_data[27] == key_data[86]
        && key_data[28] == &key_data[93:46])
        else $error("mc or bc flag wrong");
    chk_depth_tag: assert property (
        key_valid |-> key_depth == DEPTH_FULL
        || key_depth == DEPTH_HALF && key_data[3:0] == HT_IP6)
        else $error("bad depth tag");
    cover property (key_valid && key_ready && key_first);
    cover property (key_valid && !key_ready);
    cover property (fr_valid && !fr_ready);
    cover property (key_valid && key_depth == DEPTH_HALF);
endmodule

bind ahk_half_key_builder ahk_chk u_chk (.pclk, .presetn, .fr_valid,
    .fr_ready, .key_valid, .key_ready, .key_data, .key_care, .key_first,
    .key_depth);

// ===== test/ahk_half_key_builder_tb_top.sv
`timescale 1ns/1ns
module ahk_half_key_builder_tb_top;
    import ahk_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, slow;
    logic fr_valid, fr_ready, host_match, host_used, fr_dei;
    logic key_valid, key_ready, key_first;
    logic [11:0]  paddr, fr_vid;
    logic [31:0]  pwdata, prdata, q;
    logic [3:0]   fr_class, fr_port;
    logic [7:0]   policy_group, key_depth, dp;
    logic [47:0]  fr_dmac, fr_smac;
    logic [1:0]   fr_qtag_cnt;
    logic [2:0]   fr_pcp;
    logic [15:0]  fr_ethertype;
    logic [55:0]  fr_payload;
    logic [184:0] key_data, key_care, ed, ec, kd;
    logic [184:0] qd[$], qc[$];
    logic [7:0]   qp[$];
    int           bad_count = 0, cmp_count = 0, cyc = 0;

    ahk_half_key_builder DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .fr_valid, .fr_ready,
        .fr_class, .policy_group, .fr_port, .host_match, .host_used,
        .fr_dmac, .fr_smac, .fr_qtag_cnt, .fr_vid, .fr_dei, .fr_pcp,
        .fr_ethertype, .fr_payload, .key_valid, .key_ready, .key_data,
        .key_care, .key_first, .key_depth);
    ahk_key_sink PART (.pclk, .presetn, .slow, .key_ready);

    task automatic check(input string nm, input logic [184:0] s,
                         input logic [184:0] x);
        cmp_count++;
        if (s !== x) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", nm, x, s);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // called just after a rising edge; holds the request until pready,
    // then idles one edge so a following call never redrives psel at once
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // expected key from the descriptor being offered
    function automatic void mk();
        logic et;
        et = fr_class == 4'h0 || fr_class > 4'ha;
        ed = '0;
        ec = '0;
        ed[3:0] = et ? 4'h0 : (fr_class > 4'h8 ? HT_IP6 : fr_class);
        ed[12:4] = {policy_group, 1'b1};
        if (fr_port < 4'hc) ed[13 + fr_port] = 1'b1;
        ed[29:26] = {fr_qtag_cnt != 2'h0, &fr_dmac, fr_dmac[40],
                     host_match & host_used};
        ed[45:30] = {fr_pcp, fr_dei, fr_vid};
        ec[45:0] = '1;
        ec[26] = host_used;
        if (et) begin
            ed[184:46] = {fr_payload[7], fr_payload[2:1], fr_payload[23:16],
                fr_payload[55:40], fr_ethertype, fr_smac, fr_dmac};
            ec[184:46] = '1;
        end
        dp = fr_class inside {4'h9, 4'ha} ? DEPTH_HALF : DEPTH_FULL;
    endfunction

    // keeps fr_valid up between frames so back-to-back takes are tried
    task automatic send(input logic [3:0] cls);
        fr_class <= cls;
        policy_group <= 8'($urandom);
        fr_port <= 4'($urandom_range(13));
        {host_match, host_used, fr_dei, fr_pcp} <= 6'($urandom);
        fr_dmac <= cls[0] ? '1 : 48'({$urandom, $urandom});
        fr_smac <= 48'({$urandom, $urandom});
        {fr_qtag_cnt, fr_vid, fr_ethertype} <= 30'($urandom);
        fr_payload <= 56'({$urandom, $urandom});
        fr_valid <= 1'b1;
        do @(posedge pclk); while (fr_ready !== 1'b1);
        mk();
        repeat (2) begin
            qd.push_back(ed);
            qc.push_back(ec);
            qp.push_back(dp);
            ed[4] = 1'b0;
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    always @(posedge pclk) begin
        if (key_valid === 1'b1 && key_ready === 1'b1) begin
            if (qd.size() == 0) begin
                check("spare key", 1, 0);
            end else begin
                kd = qd.pop_front();
                check("key type", key_data[4:0], kd[4:0]);
                check("key first", key_first, kd[4]);
                check("key iface", key_data[25:5], kd[25:5]);
                check("key vlan", key_data[45:26], kd[45:26]);
                check("key macs", key_data[141:46], kd[141:46]);
                check("key ethertype_field", key_data[184:142], kd[184:142]);
                check("key_care", key_care, qc.pop_front());
                check("key_depth", key_depth, qp.pop_front());
            end
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {fr_valid, fr_class, policy_group, fr_port, host_match} = '0;
        {host_used, fr_dmac, fr_smac, fr_qtag_cnt, fr_vid, fr_dei} = '0;
        {fr_pcp, fr_ethertype, fr_payload} = '0;
        void'($urandom(12));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 0);
        check("ctrl reset", q, 1);
        apb(1'b0, 12'h010, 0);
        check("pslverr", e, 1);
        check("unmapped read", q, 0);
        apb(1'b1, REG_CTRL, 0);
        @(posedge pclk);
        check("fr_ready off", fr_ready, 0);
        apb(1'b1, REG_CTRL, 1);
        for (int i = 0; i < 32; i++) begin
            slow <= i[4];
            send(i[3:0]);
        end
        fr_valid <= 1'b0;
        while (qd.size() != 0) @(posedge pclk);
        @(posedge pclk);
        apb(1'b0, REG_FRAMES, 0);
        check("frames", q, 32);
        apb(1'b0, REG_KEYS, 0);
        check("keys", q, 64);
        apb(1'b0, REG_STATUS, 0);
        check("status", q, 32'(DEPTH_FULL) << ST_DEPTH_LSB);
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_FRAMES, 0);
        check("frames clr", q, 0);
        results();
    end
endmodule

// ===== test/ahk_key_sink.sv
`timescale 1ns/1ns
// match table side: takes keys, stalls most cycles when slow
module ahk_key_sink (
    input  wire logic pclk,     // core clock
    input  wire logic presetn,  // async reset
    input  wire logic slow,     // stall mode
    output logic      key_ready // key taken
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_ready <= 1'b0;
        end else begin
            key_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
        end
    end
endmodule
